// *** rtl/tfg_top.sv ***
// Test frame generator: builds Ethernet test frames toward the media side,
// steered by the control and payload pattern registers.
// Assumes register accesses arrive decoded from the management interface, one clock.
//
// Contract
// - Frames are started only while both enable and run bits are one, and a frame in progress is finished; both reset zero.
// - Duration bit zero sends exactly thirty million frames, then stops.
// - Duration bit one sends continuously, counted in blocks of ten thousand.
// - Continuous cleared mid-run: keep sending until count reaches next ten-thousand mark.
// - Length field selects 125, 64, 1518 or 10000 byte frames.
// - Gap bit selects 96 ns or 8192 ns idle between frames; the code rounds up to 4 or 328 clocks (100 ns, 8200 ns).
// - Destination address is all ones with low nibble from bits 9:6, reset 0001.
// - Source address is all ones with low nibble from bits 5:2, reset 0000.
// - Payload type one gives random payload, zero repeats the pattern register.
// - Bad checksum bit one corrupts every FCS, zero gives correct FCS.
// - Pattern register holds sixteen bits, reset zero, repeated through the payload.
// - Control bits 12:0 changed mid-run apply only after run is cleared and set again; clearing bit 13 in a continuous run acts at the next block mark.
`timescale 1ns/1ps
module tfg_top #(
	parameter int BURST_FRAMES = tfg_pkg::BURST_FRAMES_DEF,
	parameter int BLOCK_FRAMES = tfg_pkg::BLOCK_FRAMES_DEF
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic REG_WR_IN,
	input wire logic [4:0] REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	output logic [15:0] REG_RDATA_OUT,
	output logic [7:0] TX_DATA_OUT,
	output logic TX_VALID_OUT,
	output logic GEN_ACTIVE_OUT
);

	typedef struct packed {
		tfg_pkg::tfg_state_t st;
		logic [15:0] ctrl;
		logic [15:0] pat;
		logic [13:0] run_cfg;
		logic [15:0] pat_cfg;
		logic go_prev;
		logic restart;
		logic [tfg_pkg::IDX_W-1:0] idx;
		logic [tfg_pkg::GAP_W-1:0] gap;
		logic [tfg_pkg::BLK_W-1:0] blk;
		logic [tfg_pkg::TOT_W-1:0] tot;
		logic [15:0] lfsr;
		logic [7:0] tx_data;
		logic tx_valid;
		logic [15:0] rdata;
		logic active;
	} tfg_top_state_t;

	localparam logic [tfg_pkg::TOT_W-1:0] BURST_CNT = tfg_pkg::TOT_W'(BURST_FRAMES);
	localparam logic [tfg_pkg::BLK_W-1:0] BLOCK_LAST = tfg_pkg::BLK_W'(BLOCK_FRAMES - 1);
	localparam logic [tfg_pkg::GAP_W-1:0] GAP_SHORT_LAST = tfg_pkg::GAP_W'(tfg_pkg::GAP_SHORT_CYC - 1);
	localparam logic [tfg_pkg::GAP_W-1:0] GAP_LONG_LAST = tfg_pkg::GAP_W'(tfg_pkg::GAP_LONG_CYC - 1);

	tfg_top_state_t s_reg;
	tfg_top_state_t s_next;
	logic [31:0] crc_value;
	logic crc_init;
	logic crc_en;
	logic [7:0] crc_byte;

	// ==========================================================================
	// Frame checksum accumulator.
	// ==========================================================================
	tfg_crc32 u_crc (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.init_in(crc_init),
		.en_in(crc_en),
		.data_in(crc_byte),
		.crc_out(crc_value)
	);

	// ==========================================================================
	// Next-state logic: registers, run control and frame byte sequencing.
	// ==========================================================================
	always_comb begin
		logic go;
		logic start;
		logic [tfg_pkg::IDX_W-1:0] flen;
		logic [tfg_pkg::IDX_W-1:0] pay_last;
		logic [tfg_pkg::IDX_W-1:0] pidx;
		logic [tfg_pkg::GAP_W-1:0] gap_last;
		logic [7:0] b;
		logic [31:0] fcs;
		logic stop;
		s_next = s_reg;
		crc_init = 1'b0;
		crc_en = 1'b0;
		b = 8'h00;
		stop = 1'b0;
		flen = tfg_pkg::LEN_125;
		go = s_reg.ctrl[tfg_pkg::BIT_ENABLE] & s_reg.ctrl[tfg_pkg::BIT_RUN];
		start = go & ~s_reg.go_prev;
		s_next.go_prev = go;
		fcs = ~crc_value;
		pidx = s_reg.idx - tfg_pkg::IDX_PAYLOAD;

		// Frame size from the configuration captured at start.
		case (s_reg.run_cfg[tfg_pkg::LEN_MSB:tfg_pkg::LEN_LSB])
			2'b00: flen = tfg_pkg::LEN_125;
			2'b01: flen = tfg_pkg::LEN_64;
			2'b10: flen = tfg_pkg::LEN_1518;
			default: flen = tfg_pkg::LEN_JUMBO;
		endcase
		pay_last = flen - tfg_pkg::FCS_BYTES - 14'h0001;
		gap_last = s_reg.run_cfg[tfg_pkg::BIT_LONG_GAP] ? GAP_LONG_LAST : GAP_SHORT_LAST;

		// Register writes and registered read data; unmapped addresses read zero.
		if (REG_WR_IN && REG_ADDR_IN == tfg_pkg::ADDR_CONTROL) begin
			s_next.ctrl = REG_WDATA_IN;
		end
		if (REG_WR_IN && REG_ADDR_IN == tfg_pkg::ADDR_PATTERN) begin
			s_next.pat = REG_WDATA_IN;
		end
		case (REG_ADDR_IN)
			tfg_pkg::ADDR_CONTROL: s_next.rdata = s_reg.ctrl;
			tfg_pkg::ADDR_PATTERN: s_next.rdata = s_reg.pat;
			default: s_next.rdata = 16'h0000;
		endcase

		// A run toggle seen while not idle is held until the current gap ends.
		if (start && s_reg.st != tfg_pkg::TFG_IDLE) begin
			s_next.restart = 1'b1;
		end

		s_next.tx_valid = 1'b0;
		s_next.tx_data = 8'h00;
		case (s_reg.st)
			tfg_pkg::TFG_IDLE: begin
				if (start) begin
					s_next.run_cfg = s_reg.ctrl[13:0];
					s_next.pat_cfg = s_reg.pat;
					s_next.tot = '0;
					s_next.blk = '0;
					s_next.idx = '0;
					s_next.restart = 1'b0;
					s_next.st = tfg_pkg::TFG_PRE;
				end
			end
			tfg_pkg::TFG_PRE: begin
				crc_init = 1'b1;
				s_next.tx_valid = 1'b1;
				s_next.tx_data = (s_reg.idx == tfg_pkg::PREAMBLE_LAST) ? tfg_pkg::SFD_BYTE
					: tfg_pkg::PREAMBLE_BYTE;
				s_next.idx = s_reg.idx + 14'h0001;
				if (s_reg.idx == tfg_pkg::PREAMBLE_LAST) begin
					s_next.idx = '0;
					s_next.st = tfg_pkg::TFG_DATA;
				end
			end
			tfg_pkg::TFG_DATA: begin
				if (s_reg.idx < tfg_pkg::IDX_SA) begin
					b = (s_reg.idx == tfg_pkg::IDX_SA - 14'h0001)
						? {4'hf, s_reg.run_cfg[tfg_pkg::DA_MSB:tfg_pkg::DA_LSB]} : 8'hff;
				end else if (s_reg.idx < tfg_pkg::IDX_TYPE) begin
					b = (s_reg.idx == tfg_pkg::IDX_TYPE - 14'h0001)
						? {4'hf, s_reg.run_cfg[tfg_pkg::SA_MSB:tfg_pkg::SA_LSB]} : 8'hff;
				end else if (s_reg.idx < tfg_pkg::IDX_PAYLOAD) begin
					// Length field carries the payload byte count, high byte first.
					if (s_reg.idx != tfg_pkg::IDX_TYPE) begin
						b = 8'(flen - tfg_pkg::HDR_FCS_BYTES);
					end else begin
						b = {2'b00, 6'((flen - tfg_pkg::HDR_FCS_BYTES) >> 8)};
					end
				end else if (s_reg.run_cfg[tfg_pkg::BIT_RANDOM]) begin
					b = s_reg.lfsr[7:0];
					s_next.lfsr = {s_reg.lfsr[14:0],
						s_reg.lfsr[15] ^ s_reg.lfsr[13] ^ s_reg.lfsr[12] ^ s_reg.lfsr[10]};
				end else begin
					b = pidx[0] ? s_reg.pat_cfg[7:0] : s_reg.pat_cfg[15:8];
				end
				crc_en = 1'b1;
				s_next.tx_valid = 1'b1;
				s_next.tx_data = b;
				s_next.idx = s_reg.idx + 14'h0001;
				if (s_reg.idx == pay_last) begin
					s_next.idx = '0;
					s_next.st = tfg_pkg::TFG_FCS;
				end
			end
			tfg_pkg::TFG_FCS: begin
				s_next.tx_valid = 1'b1;
				s_next.tx_data = fcs[s_reg.idx[1:0]*8 +: 8];
				if (s_reg.idx == 14'h0000 && s_reg.run_cfg[tfg_pkg::BIT_BAD_FCS]) begin
					s_next.tx_data = fcs[7:0] ^ 8'h01;
				end
				s_next.idx = s_reg.idx + 14'h0001;
				if (s_reg.idx == tfg_pkg::FCS_BYTES - 14'h0001) begin
					s_next.idx = '0;
					s_next.gap = '0;
					s_next.tot = s_reg.tot + 25'h0000001;
					s_next.blk = (s_reg.blk == BLOCK_LAST) ? '0 : s_reg.blk + 14'h0001;
					s_next.st = tfg_pkg::TFG_GAP;
				end
			end
			tfg_pkg::TFG_GAP: begin
				s_next.gap = s_reg.gap + 9'h001;
				if (s_reg.gap == gap_last) begin
					if (!go) begin
						stop = 1'b1;
					end else if (!s_reg.run_cfg[tfg_pkg::BIT_CONTINUOUS] && s_reg.tot == BURST_CNT) begin
						stop = 1'b1;
					end else if (s_reg.run_cfg[tfg_pkg::BIT_CONTINUOUS]
						&& !s_reg.ctrl[tfg_pkg::BIT_CONTINUOUS] && s_reg.blk == '0) begin
						stop = 1'b1;
					end
					if (s_reg.restart && go) begin
						s_next.run_cfg = s_reg.ctrl[13:0];
						s_next.pat_cfg = s_reg.pat;
						s_next.tot = '0;
						s_next.blk = '0;
						s_next.restart = 1'b0;
						s_next.st = tfg_pkg::TFG_PRE;
					end else begin
						// A run toggle seen in this very cycle must survive, so the flag is kept.
						s_next.st = stop ? tfg_pkg::TFG_IDLE : tfg_pkg::TFG_PRE;
					end
				end
			end
			default: begin
				s_next.st = tfg_pkg::TFG_IDLE;
			end
		endcase
		s_next.active = (s_next.st != tfg_pkg::TFG_IDLE);
		crc_byte = b;
	end

	// ==========================================================================
	// State register.
	// ==========================================================================
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			s_reg <= '{st: tfg_pkg::TFG_IDLE, ctrl: tfg_pkg::CONTROL_RESET,
				pat: tfg_pkg::PATTERN_RESET, run_cfg: 14'h0000, pat_cfg: 16'h0000,
				go_prev: 1'b0, restart: 1'b0, idx: '0, gap: '0, blk: '0, tot: '0,
				lfsr: tfg_pkg::LFSR_SEED, tx_data: 8'h00, tx_valid: 1'b0, rdata: 16'h0000,
				active: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register.
	assign REG_RDATA_OUT = s_reg.rdata;
	assign TX_DATA_OUT = s_reg.tx_data;
	assign TX_VALID_OUT = s_reg.tx_valid;
	assign GEN_ACTIVE_OUT = s_reg.active;

endmodule : tfg_top

// *** rtl/tfg_pkg.sv ***
// Constants shared by the test frame generator: register map, field layout,
// reset values, frame layout and timing.
// Assumes a single 40 MHz core clock and the extended register port of the device.
package tfg_pkg;

	// ==========================================================================
	// Register map and field positions.
	// ==========================================================================
	localparam logic [4:0] ADDR_CONTROL = 5'h1d;
	localparam logic [4:0] ADDR_PATTERN = 5'h1e;
	localparam logic [15:0] CONTROL_RESET = 16'h0040;
	localparam logic [15:0] PATTERN_RESET = 16'h0000;
	localparam int BIT_ENABLE = 15;
	localparam int BIT_RUN = 14;
	localparam int BIT_CONTINUOUS = 13;
	localparam int LEN_MSB = 12;
	localparam int LEN_LSB = 11;
	localparam int BIT_LONG_GAP = 10;
	localparam int DA_MSB = 9;
	localparam int DA_LSB = 6;
	localparam int SA_MSB = 5;
	localparam int SA_LSB = 2;
	localparam int BIT_RANDOM = 1;
	localparam int BIT_BAD_FCS = 0;

	// ==========================================================================
	// Frame layout, counted in bytes from the first destination address byte.
	// ==========================================================================
	localparam int IDX_W = 14;
	localparam logic [IDX_W-1:0] LEN_125 = 14'h007d;
	localparam logic [IDX_W-1:0] LEN_64 = 14'h0040;
	localparam logic [IDX_W-1:0] LEN_1518 = 14'h05ee;
	localparam logic [IDX_W-1:0] LEN_JUMBO = 14'h2710;
	localparam logic [IDX_W-1:0] IDX_SA = 14'h0006;
	localparam logic [IDX_W-1:0] IDX_TYPE = 14'h000c;
	localparam logic [IDX_W-1:0] IDX_PAYLOAD = 14'h000e;
	localparam logic [IDX_W-1:0] HDR_FCS_BYTES = 14'h0012;
	localparam logic [IDX_W-1:0] FCS_BYTES = 14'h0004;
	localparam logic [IDX_W-1:0] PREAMBLE_LAST = 14'h0007;
	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	// ==========================================================================
	// Timing: gaps in ns, turned into whole clock cycles, rounded up.
	// ==========================================================================
	localparam int CLK_PERIOD_PS = 25000;
	localparam int GAP_SHORT_NS = 96;
	localparam int GAP_LONG_NS = 8192;
	localparam int GAP_SHORT_CYC = (GAP_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_LONG_CYC = (GAP_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_W = 9;

	// Frame counters.
	localparam int BURST_FRAMES_DEF = 30000000;
	localparam int BLOCK_FRAMES_DEF = 10000;
	localparam int TOT_W = 25;
	localparam int BLK_W = 14;

	// Generator states, one-hot.
	typedef enum logic [4:0] {
		TFG_IDLE = 5'h01,
		TFG_PRE = 5'h02,
		TFG_DATA = 5'h04,
		TFG_FCS = 5'h08,
		TFG_GAP = 5'h10
	} tfg_state_t;

endpackage : tfg_pkg

// *** rtl/tfg_crc32.sv ***
// Byte-wide Ethernet CRC-32 accumulator for the test frame generator.
// Assumes the caller clears it before a frame and feeds one byte per enabled cycle.
`timescale 1ns/1ps
module tfg_crc32 (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic init_in,
	input wire logic en_in,
	input wire logic [7:0] data_in,
	output logic [31:0] crc_out
);

	typedef struct packed {
		logic [31:0] crc;
	} tfg_crc_state_t;

	tfg_crc_state_t state_reg;
	tfg_crc_state_t state_next;

	// ==========================================================================
	// Reflected CRC update, one bit per loop pass.
	// ==========================================================================
	always_comb begin
		logic [31:0] c;
		c = state_reg.crc ^ {24'h000000, data_in};
		state_next = state_reg;
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ tfg_pkg::CRC_POLY) : (c >> 1);
		end
		if (init_in) begin
			state_next.crc = tfg_pkg::CRC_INIT;
		end else if (en_in) begin
			state_next.crc = c;
		end
	end

	// Register the state.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= '{crc: tfg_pkg::CRC_INIT};
		end else begin
			state_reg <= state_next;
		end
	end

	assign crc_out = state_reg.crc;

endmodule : tfg_crc32

// *** tb/tfg_monitor.sv ***
// Checker for the test frame generator top module ports.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ps
module tfg_monitor #(
	parameter int BURST_FRAMES = 5,
	parameter int BLOCK_FRAMES = 3
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic REG_WR_IN,
	input wire logic [4:0] REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic [15:0] REG_RDATA_OUT,
	input wire logic [7:0] TX_DATA_OUT,
	input wire logic TX_VALID_OUT,
	input wire logic GEN_ACTIVE_OUT
);
	// ====
	// Shadow of the go bits and length of the current valid run.
	logic go_reg;
	logic [13:0] vlen_reg;
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			go_reg <= 1'b0;
			vlen_reg <= 14'h0000;
		end else begin
			if (REG_WR_IN && REG_ADDR_IN == 5'h1d) begin
				go_reg <= &REG_WDATA_IN[15:14];
			end
			vlen_reg <= TX_VALID_OUT ? vlen_reg + 14'h0001 : 14'h0000;
		end
	end
	// ====
	// Frame head sequences and the port properties, of which only a_frame_head uses them.
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RST_IN);
	sequence s_pre;
		(TX_VALID_OUT && TX_DATA_OUT == 8'h55) [*7] ##1 TX_DATA_OUT == 8'hd5;
	endsequence
	sequence s_ones;
		(TX_DATA_OUT == 8'hff) [*5] ##1 1'b1 ##1 (TX_DATA_OUT == 8'hff) [*5];
	endsequence
	a_reset_quiet: assert property ($fell(RST_IN) |-> !TX_VALID_OUT && !GEN_ACTIVE_OUT)
		else $error("Generator busy after reset.");
	a_valid_active: assert property (TX_VALID_OUT |-> GEN_ACTIVE_OUT)
		else $error("Byte sent while generator idle.");
	a_idle_hold: assert property (!go_reg && !REG_WR_IN && !GEN_ACTIVE_OUT |=> !GEN_ACTIVE_OUT)
		else $error("Generator woke without enable and run.");
	a_frame_head: assert property ($rose(TX_VALID_OUT) |-> s_pre ##1 s_ones)
		else $error("Bad preamble or address head.");
	a_gap_min: assert property ($fell(TX_VALID_OUT) |-> !TX_VALID_OUT [*4])
		else $error("Gap shorter than four cycles.");
	a_frame_len: assert property ($fell(TX_VALID_OUT) |->
		vlen_reg inside {14'h0048, 14'h0085, 14'h05f6, 14'h2718})
		else $error("Frame of illegal length.");
	a_start_time: assert property (REG_WR_IN && REG_ADDR_IN == 5'h1d && &REG_WDATA_IN[15:14]
		&& !go_reg && !GEN_ACTIVE_OUT |-> ##[2:5] TX_VALID_OUT)
		else $error("Start did not begin a frame.");
	a_read_back: assert property ((REG_WR_IN && REG_ADDR_IN == 5'h1e) ##1 (REG_ADDR_IN == 5'h1e && !REG_WR_IN)
		|=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
		else $error("Pattern register read back wrong.");
endmodule : tfg_monitor

bind tfg_top tfg_monitor #(.BURST_FRAMES(BURST_FRAMES), .BLOCK_FRAMES(BLOCK_FRAMES)) i_monitor (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .TX_DATA_OUT(TX_DATA_OUT),
	.TX_VALID_OUT(TX_VALID_OUT), .GEN_ACTIVE_OUT(GEN_ACTIVE_OUT));

// *** tb/tfg_link_partner.sv ***
// Link partner model: receives generated frames and checks their FCS.
// Assumes one byte per clock while valid is high, with no back-pressure.
`timescale 1ns/1ps
module tfg_link_partner (
	input wire logic clk_in,
	input wire logic valid_in,
	input wire logic [7:0] data_in
);
	logic [7:0] cur[$];
	logic [7:0] fr[$];
	logic [31:0] crc;
	logic prev_valid = 1'b0;
	logic crc_ok = 1'b0;
	int n_frames = 0;
	int gap_cnt = 0;
	int last_gap = 0;
	// Collects each frame, keeps it without preamble, and checks its FCS.
	always @(posedge clk_in) begin
		if (valid_in && !prev_valid) begin
			last_gap = gap_cnt;
			cur.delete();
		end
		gap_cnt = valid_in ? 0 : gap_cnt + 1;
		if (valid_in) begin
			cur.push_back(data_in);
		end
		if (!valid_in && prev_valid) begin
			fr = cur[8:$];
			crc = 32'hffffffff;
			for (int i = 0; i < fr.size() - 4; i++) begin
				crc = crc ^ {24'h000000, fr[i]};
				for (int b = 0; b < 8; b++) begin
					crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
				end
			end
			crc_ok = (~crc === {fr[$], fr[$-1], fr[$-2], fr[$-3]});
			n_frames++;
		end
		prev_valid = valid_in;
	end
endmodule : tfg_link_partner

// *** tb/tfg_top_tb.sv ***
// Testbench for the test frame generator with a receiving link partner.
// Assumes short burst and block counts; the partner is no live network.
`timescale 1ns/1ps
module tfg_top_tb;
	localparam int NB = 5;
	localparam int NK = 3;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [7:0] txd;
	logic txv;
	logic act;
	int n_mismatch = 0;
	int n_compared = 0;
	int base;

	tfg_top #(.BURST_FRAMES(NB), .BLOCK_FRAMES(NK)) i_dut (.SYS_CLK_IN(clk), .RST_IN(rst),
		.REG_WR_IN(wr_en), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .GEN_ACTIVE_OUT(act));
	tfg_link_partner i_link (.clk_in(clk), .valid_in(txv), .data_in(txd));

	// ====
	// Clock, watchdog and common tasks.
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1 d = rdata;
	endtask : rd
	task automatic wait_frames(input int n);
		for (int i = 0; i < 40000 && i_link.n_frames < n; i++) @(posedge clk);
	endtask : wait_frames
	task automatic wait_idle();
		for (int i = 0; i < 40000 && act !== 1'b0; i++) @(posedge clk);
		#1;
	endtask : wait_idle
	task automatic start(input logic [15:0] cfg);
		base = i_link.n_frames;
		wr(5'h1d, cfg);
		wr(5'h1d, cfg | 16'hc000);
	endtask : start
	task automatic chk_frame(input int len, input logic [7:0] da, input logic [7:0] sa, input logic ok);
		chk("frame length", 32'(len), 32'(i_link.fr.size()));
		chk("dest high", 32'h000000ff, {24'h0, i_link.fr[0]});
		chk("dest low", {24'h0, da}, {24'h0, i_link.fr[5]});
		chk("src high", 32'h000000ff, {24'h0, i_link.fr[6]});
		chk("src low", {24'h0, sa}, {24'h0, i_link.fr[11]});
		chk("length field", 32'(len - 18), {16'h0, i_link.fr[12], i_link.fr[13]});
		chk("fcs good", {31'h0, ok}, {31'h0, i_link.crc_ok});
	endtask : chk_frame

	// ====
	// Scenarios.
	task automatic t_regs();
		logic [15:0] d;
		rd(5'h1d, d);
		chk("ctrl reset", 32'h00000040, {16'h0, d});
		rd(5'h1e, d);
		chk("pattern reset", 32'h0, {16'h0, d});
		wr(5'h1e, 16'ha5c3);
		wr(5'h07, 16'hffff);
		rd(5'h07, d);
		chk("unmapped", 32'h0, {16'h0, d});
		wr(5'h1d, 16'h4000);
		repeat (20) @(posedge clk);
		#1;
		chk("idle without enable", 32'h0, {31'h0, act});
	endtask : t_regs
	task automatic t_burst();
		start(16'h0968);
		wait_frames(base + 1);
		wr(5'h1e, 16'h1234);
		wait_idle();
		chk("burst count", 32'(base + NB), 32'(i_link.n_frames));
		chk_frame(64, 8'hf5, 8'hfa, 1'b1);
		chk("payload hi", 32'h000000a5, {24'h0, i_link.fr[14]});
		chk("payload lo", 32'h000000c3, {24'h0, i_link.fr[59]});
	endtask : t_burst
	task automatic t_sizes();
		int lens[2] = '{125, 1518};
		for (int k = 0; k < 2; k++) begin
			start({3'b000, k[0], 2'b00, 4'h3, 4'hc, ~k[0], ~k[0]});
			wait_frames(base + 1);
			wait_idle();
			chk("burst count", 32'(base + NB), 32'(i_link.n_frames));
			chk_frame(lens[k], 8'hf3, 8'hfc, k[0]);
		end
		chk("new pattern", 32'h00000012, {24'h0, i_link.fr[14]});
	endtask : t_sizes
	task automatic t_stop();
		start(16'h1040);
		for (int i = 0; i < 50 && txv !== 1'b1; i++) @(posedge clk);
		wr(5'h1d, 16'h9040);
		wait_idle();
		chk("frames after stop", 32'(base + 1), 32'(i_link.n_frames));
		chk("whole frame", 32'd1518, 32'(i_link.fr.size()));
	endtask : t_stop
	task automatic t_restart();
		start(16'h0d68);
		wait_frames(base + 1);
		start(16'h0e68);
		wait_idle();
		chk("restart count", 32'(base + NB), 32'(i_link.n_frames));
		chk("restart dest", 32'h000000f9, {24'h0, i_link.fr[5]});
	endtask : t_restart
	task automatic t_cont();
		start(16'h3c40);
		wait_frames(base + 1);
		wr(5'h1d, 16'hfdc0);
		wait_frames(base + 2);
		chk("dest kept", 32'h000000f1, {24'h0, i_link.fr[5]});
		chk("long gap", 32'd328, 32'(i_link.last_gap));
		wr(5'h1d, 16'hddc0);
		wait_idle();
		chk("block end", 32'(base + NK), 32'(i_link.n_frames));
	endtask : t_cont

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_burst();
		t_sizes();
		t_stop();
		t_restart();
		t_cont();
		end_of_test();
	end
endmodule : tfg_top_tb
